//--- src/bsp_port_group.sv
// Top of the bus strobe port group: APB registers and three pin ports
`timescale 1ns/1ns

// How it works
// - Two chip-select pins, each with own direction and chip-select function switch.
// - Strobe pins at bits 0,1,4,6 with own direction; other bits read zero.
// - Six upper-address pins with direction control, or address lines 16 to 21.
// - Chip-select pin in output mode drives its latch bit level.
// - Chip-select latch resets to zero, uses bits 0 and 1 only.
// - Strobe latch resets to zero and sets each output pin level.
// - Chip-select direction bit 0 is output, 1 input; resets all ones.
// - Chip-select function bit 1 routes chip select to pin; resets zero.
// - Strobe function bits route write strobes, read and address strobe; reset zero.
// - Every pin of all three ports has a software-controlled pull-up.
// - Pull-up bit 0 leaves resistor off, 1 connects it.
module bsp_port_group
	import bsp_pkg::*;
#(
	parameter int ADDR_W = BSP_ADDR_W
) (
	input wire logic i_clock,
	input wire logic i_rst,
	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// ----------------------------------------
	// Bus controller signals
	// ----------------------------------------
	input wire logic [1:0] i_chip_select,
	input wire logic [1:0] i_write_strobe,
	input wire logic i_read_strobe,
	input wire logic i_address_strobe,
	input wire logic [5:0] i_upper_address,
	// ----------------------------------------
	// Pads
	// ----------------------------------------
	input wire logic [1:0] i_cs_pin,
	output logic [1:0] o_cs_pin,
	output logic [1:0] o_cs_pin_oe,
	output logic [1:0] o_cs_pullup,
	input wire logic [3:0] i_st_pin,
	output logic [3:0] o_st_pin,
	output logic [3:0] o_st_pin_oe,
	output logic [3:0] o_st_pullup,
	input wire logic [5:0] i_ua_pin,
	output logic [5:0] o_ua_pin,
	output logic [5:0] o_ua_pin_oe,
	output logic [5:0] o_ua_pullup
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (ADDR_W != BSP_ADDR_W) begin : g_bad_addr_w
		$error("ADDR_W must equal the decoded address width");
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] cs_latch_q;
	logic [7:0] cs_dir_q;
	logic [7:0] cs_fsel_q;
	logic [7:0] cs_pu_q;
	logic [7:0] st_latch_q;
	logic [7:0] st_dir_q;
	logic [7:0] st_fsel_q;
	logic [7:0] st_pu_q;
	logic [7:0] ua_latch_q;
	logic [7:0] ua_dir_q;
	logic [7:0] ua_fsel_q;
	logic [7:0] ua_pu_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic pslverr_d;
	logic [31:0] prdata_d;
	logic wr_go;
	logic [7:0] wbyte;

	bsp_pad_t cs_pad;
	bsp_pad_t st_pad;
	bsp_pad_t ua_pad;
	logic [7:0] cs_read;
	logic [7:0] st_read;
	logic [7:0] ua_read;

	// Writes land only in the access cycle, and only with byte lane 0
	assign wr_go = i_psel & i_penable & pready_q & i_pwrite & i_pstrb[0] & ~pslverr_q;
	assign wbyte = i_pwdata[7:0];

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
		hit = (a == bsp_addr(idx));
	endfunction : hit

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	// One setup edge prepares the answer, so every access ends with no wait state
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= i_psel & ~i_penable;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (i_psel & ~i_penable) begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end else if (~i_psel) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		case (1'b1)
			hit(i_paddr, CS_LATCH_IDX): prdata_d[7:0] = cs_read;
			hit(i_paddr, CS_DIR_IDX): prdata_d[7:0] = cs_dir_q;
			hit(i_paddr, CS_FSEL_IDX): prdata_d[7:0] = cs_fsel_q;
			hit(i_paddr, CS_PU_IDX): prdata_d[7:0] = cs_pu_q;
			hit(i_paddr, ST_LATCH_IDX): prdata_d[7:0] = st_read;
			hit(i_paddr, ST_DIR_IDX): prdata_d[7:0] = st_dir_q & ST_MASK;
			hit(i_paddr, ST_FSEL_IDX): prdata_d[7:0] = st_fsel_q;
			hit(i_paddr, ST_PU_IDX): prdata_d[7:0] = st_pu_q;
			hit(i_paddr, UA_LATCH_IDX): prdata_d[7:0] = ua_read;
			hit(i_paddr, UA_DIR_IDX): prdata_d[7:0] = ua_dir_q & UA_MASK;
			hit(i_paddr, UA_FSEL_IDX): prdata_d[7:0] = ua_fsel_q;
			hit(i_paddr, UA_PU_IDX): prdata_d[7:0] = ua_pu_q;
			default: pslverr_d = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Chip-select port registers
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cs_latch_q <= LATCH_RST;
		end else if (wr_go & hit(i_paddr, CS_LATCH_IDX)) begin
			cs_latch_q <= wbyte & CS_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cs_dir_q <= DIR_RST;
		end else if (wr_go & hit(i_paddr, CS_DIR_IDX)) begin
			// Unused bits keep reading one, as after reset
			cs_dir_q <= wbyte | ~CS_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cs_fsel_q <= FSEL_RST;
		end else if (wr_go & hit(i_paddr, CS_FSEL_IDX)) begin
			cs_fsel_q <= wbyte & CS_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cs_pu_q <= PU_RST;
		end else if (wr_go & hit(i_paddr, CS_PU_IDX)) begin
			cs_pu_q <= wbyte & CS_MASK;
		end
	end

	// ----------------------------------------
	// Strobe port registers
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_latch_q <= LATCH_RST;
		end else if (wr_go & hit(i_paddr, ST_LATCH_IDX)) begin
			st_latch_q <= wbyte & ST_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_dir_q <= DIR_RST;
		end else if (wr_go & hit(i_paddr, ST_DIR_IDX)) begin
			st_dir_q <= wbyte | ~ST_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_fsel_q <= FSEL_RST;
		end else if (wr_go & hit(i_paddr, ST_FSEL_IDX)) begin
			st_fsel_q <= wbyte & ST_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_pu_q <= PU_RST;
		end else if (wr_go & hit(i_paddr, ST_PU_IDX)) begin
			st_pu_q <= wbyte & ST_MASK;
		end
	end

	// ----------------------------------------
	// Upper-address port registers
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ua_latch_q <= LATCH_RST;
		end else if (wr_go & hit(i_paddr, UA_LATCH_IDX)) begin
			ua_latch_q <= wbyte & UA_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ua_dir_q <= DIR_RST;
		end else if (wr_go & hit(i_paddr, UA_DIR_IDX)) begin
			ua_dir_q <= wbyte | ~UA_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ua_fsel_q <= FSEL_RST;
		end else if (wr_go & hit(i_paddr, UA_FSEL_IDX)) begin
			ua_fsel_q <= wbyte & UA_MASK;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ua_pu_q <= PU_RST;
		end else if (wr_go & hit(i_paddr, UA_PU_IDX)) begin
			ua_pu_q <= wbyte & UA_MASK;
		end
	end

	// ----------------------------------------
	// Pin multiplexers
	// ----------------------------------------
	bsp_port_mux #(
		.MASK(CS_MASK)
	) u_cs_mux (
		.i_latch(cs_latch_q),
		.i_dir(cs_dir_q),
		.i_fsel(cs_fsel_q),
		.i_pu(cs_pu_q),
		.i_alt({6'b00_0000, i_chip_select}),
		.i_pin({6'b00_0000, i_cs_pin}),
		.o_pad(cs_pad),
		.o_read(cs_read)
	);

	bsp_port_mux #(
		.MASK(ST_MASK)
	) u_st_mux (
		.i_latch(st_latch_q),
		.i_dir(st_dir_q),
		.i_fsel(st_fsel_q),
		.i_pu(st_pu_q),
		// Bits 0,1,4,6: write strobe 0, write strobe 1, read strobe, address strobe
		.i_alt(bsp_spread({i_address_strobe, i_read_strobe, i_write_strobe})),
		.i_pin(bsp_spread(i_st_pin)),
		.o_pad(st_pad),
		.o_read(st_read)
	);

	bsp_port_mux #(
		.MASK(UA_MASK)
	) u_ua_mux (
		.i_latch(ua_latch_q),
		.i_dir(ua_dir_q),
		.i_fsel(ua_fsel_q),
		.i_pu(ua_pu_q),
		.i_alt({2'b00, i_upper_address}),
		.i_pin({2'b00, i_ua_pin}),
		.o_pad(ua_pad),
		.o_read(ua_read)
	);

	// ----------------------------------------
	// Registered pad outputs
	// ----------------------------------------
	// Costs one cycle of strobe latency, bought for glitch-free pads
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_cs_pin <= 2'h0;
			o_cs_pin_oe <= 2'h0;
			o_cs_pullup <= 2'h0;
		end else begin
			o_cs_pin <= cs_pad.out[1:0];
			o_cs_pin_oe <= cs_pad.oe[1:0];
			o_cs_pullup <= cs_pad.pu[1:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_st_pin <= 4'h0;
			o_st_pin_oe <= 4'h0;
			o_st_pullup <= 4'h0;
		end else begin
			o_st_pin <= bsp_pack(st_pad.out);
			o_st_pin_oe <= bsp_pack(st_pad.oe);
			o_st_pullup <= bsp_pack(st_pad.pu);
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_ua_pin <= 6'h00;
			o_ua_pin_oe <= 6'h00;
			o_ua_pullup <= 6'h00;
		end else begin
			o_ua_pin <= ua_pad.out[5:0];
			o_ua_pin_oe <= ua_pad.oe[5:0];
			o_ua_pullup <= ua_pad.pu[5:0];
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;

endmodule : bsp_port_group

//--- src/bsp_pkg.sv
// Shared constants, pad bundle type and helpers for the bus strobe port group
package bsp_pkg;

	// ----------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [31:0] CS_LATCH_IDX = 32'hffff_f008;
	localparam logic [31:0] ST_LATCH_IDX = 32'hffff_f00a;
	localparam logic [31:0] CS_DIR_IDX = 32'hffff_f028;
	localparam logic [31:0] CS_FSEL_IDX = 32'hffff_f048;
	localparam logic [31:0] ST_FSEL_IDX = 32'hffff_f04a;
	localparam logic [31:0] ST_DIR_IDX = 32'hffff_f02a;
	localparam logic [31:0] CS_PU_IDX = 32'hffff_f068;
	localparam logic [31:0] ST_PU_IDX = 32'hffff_f06a;
	localparam logic [31:0] UA_LATCH_IDX = 32'hffff_f006;
	localparam logic [31:0] UA_DIR_IDX = 32'hffff_f026;
	localparam logic [31:0] UA_FSEL_IDX = 32'hffff_f046;
	localparam logic [31:0] UA_PU_IDX = 32'hffff_f066;

	// ----------------------------------------
	// Decoded address width and reset values
	// ----------------------------------------
	localparam int BSP_ADDR_W = 12;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [7:0] FSEL_RST = 8'h00;
	localparam logic [7:0] PU_RST = 8'h00;

	// ----------------------------------------
	// Implemented bit masks
	// ----------------------------------------
	localparam logic [7:0] CS_MASK = 8'h03;
	localparam logic [7:0] ST_MASK = 8'h53;
	localparam logic [7:0] UA_MASK = 8'h3f;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} bsp_pad_t;

	// Byte address from register index, low decoded bits only
	function automatic logic [BSP_ADDR_W-1:0] bsp_addr(input logic [31:0] idx);
		bsp_addr = {idx[BSP_ADDR_W-3:0], 2'b00};
	endfunction : bsp_addr

	// Strobe pins sit at register bits 0, 1, 4 and 6
	function automatic logic [3:0] bsp_pack(input logic [7:0] v);
		bsp_pack = {v[6], v[4], v[1], v[0]};
	endfunction : bsp_pack

	function automatic logic [7:0] bsp_spread(input logic [3:0] v);
		bsp_spread = {1'b0, v[3], 1'b0, v[2], 2'b00, v[1], v[0]};
	endfunction : bsp_spread

endpackage : bsp_pkg

//--- src/bsp_port_mux.sv
// Per-port pin multiplexer: general I/O or alternate function
`timescale 1ns/1ns
module bsp_port_mux
	import bsp_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hff
) (
	input wire logic [7:0] i_latch,
	input wire logic [7:0] i_dir,
	input wire logic [7:0] i_fsel,
	input wire logic [7:0] i_pu,
	input wire logic [7:0] i_alt,
	input wire logic [7:0] i_pin,
	output bsp_pad_t o_pad,
	output logic [7:0] o_read
);

	always_comb begin
		// Alternate function overrides latch and direction
		o_pad.out = ((i_fsel & i_alt) | (~i_fsel & i_latch)) & MASK;
		o_pad.oe = (i_fsel | ~i_dir) & MASK;
		o_pad.pu = i_pu & MASK;
		// Input pins read the pad level, others the latch
		o_read = ((i_dir & ~i_fsel & i_pin) | (~(i_dir & ~i_fsel) & i_latch)) & MASK;
	end

endmodule : bsp_port_mux

//--- tb/bsp_assertions.sv
// Port-level checks for the bus strobe port group
`timescale 1ns/1ns
module bsp_assertions #(
	parameter int ADDR_W = 12
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [1:0] i_chip_select,
	input wire logic [1:0] o_cs_pin,
	input wire logic [1:0] o_cs_pin_oe,
	input wire logic [3:0] o_st_pin_oe,
	input wire logic [5:0] o_ua_pin_oe
);
	// ------
	// Checks
	// ------
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	wire rd_ack = o_pready && !i_pwrite;
	wire mapped = i_paddr inside {12'h018, 12'h020, 12'h028, 12'h098, 12'h0a0, 12'h0a8,
		12'h118, 12'h120, 12'h128, 12'h198, 12'h1a0, 12'h1a8};
	ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
		else $error("ready missing after setup");
	ready_single_a: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	error_on_unmapped_a: assert property (i_psel && !i_penable |=> o_pslverr == !$past(mapped))
		else $error("error flag does not match address map");
	cs_latch_zero_a: assert property (rd_ack && i_paddr == 12'h020 |-> o_prdata[31:2] == 0)
		else $error("unused chip-select latch bits set");
	st_latch_zero_a: assert property (rd_ack && i_paddr == 12'h028 |->
		(o_prdata & 32'hffff_ffac) == 0) else $error("unused strobe latch bits set");
	fsel_unused_a: assert property (rd_ack && (i_paddr == 12'h120 || i_paddr == 12'h128) |->
		(o_prdata & ((i_paddr == 12'h120) ? 32'hffff_fffc : 32'hffff_ffac)) == 0)
		else $error("unused function bits set");
	cs_dir_ones_a: assert property (rd_ack && i_paddr == 12'h0a0 |-> o_prdata[31:2] == 30'h3f)
		else $error("unused chip-select direction bits wrong");
	pins_input_reset_a: assert property ($fell(i_rst) |->
		o_cs_pin_oe == 0 && o_st_pin_oe == 0 && o_ua_pin_oe == 0) else $error("pin driven after reset");
	cs_pin_cause_a: assert property ($changed(o_cs_pin) |->
		$past(i_chip_select) != $past(i_chip_select, 2) || $past(o_pready && i_pwrite) ||
		$past(o_pready && i_pwrite, 2) || $past(o_pready && i_pwrite, 3))
		else $error("chip-select pin moved without cause");
endmodule : bsp_assertions

bind bsp_port_group bsp_assertions #(.ADDR_W(ADDR_W)) u_chk (.i_clock(i_clock), .i_rst(i_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_chip_select(i_chip_select), .o_cs_pin(o_cs_pin), .o_cs_pin_oe(o_cs_pin_oe),
	.o_st_pin_oe(o_st_pin_oe), .o_ua_pin_oe(o_ua_pin_oe));

//--- tb/bsp_partner.sv
// Far-side model: bus controller strobes and pad wiring
`timescale 1ns/1ns
module bsp_partner (
	input wire logic i_clock,
	input wire logic [11:0] i_out,
	input wire logic [11:0] i_oe,
	input wire logic [11:0] i_pu,
	output logic [11:0] o_pin,
	output logic [11:0] o_alt = 12'h000
);
	logic [11:0] ext_q = 12'h000;
	// Controller levels move every cycle to expose stale muxing
	always @(posedge i_clock) begin
		o_alt <= 12'($urandom);
		ext_q <= ~ext_q;
	end
	// Floating pins flip each cycle so a missing pull-up shows
	assign o_pin = (i_oe & i_out) | (~i_oe & (i_pu | ext_q));
endmodule : bsp_partner

//--- tb/tb_top.sv
// Self-checking bench for the bus strobe port group
`timescale 1ns/1ns
module tb_top
	import bsp_pkg::*;
;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0] pstrb = 4'h0;
	logic lane0 = 1'b1;
	wire [11:0] p_out, p_oe, p_pu, p_pin, p_alt;
	logic [7:0] rg[12];
	logic [7:0] mk[3] = '{CS_MASK, ST_MASK, UA_MASK};
	logic [11:0] ad[12] = '{12'h020, 12'h028, 12'h018, 12'h0a0, 12'h0a8, 12'h098,
		12'h120, 12'h128, 12'h118, 12'h1a0, 12'h1a8, 12'h198};
	int fails = 0, n_checks = 0;
	always #50 i_clock = ~i_clock;
	bsp_port_group DUT (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_chip_select(p_alt[1:0]), .i_write_strobe(p_alt[3:2]), .i_read_strobe(p_alt[4]),
		.i_address_strobe(p_alt[5]), .i_upper_address(p_alt[11:6]),
		.i_cs_pin(p_pin[1:0]), .o_cs_pin(p_out[1:0]), .o_cs_pin_oe(p_oe[1:0]),
		.o_cs_pullup(p_pu[1:0]), .i_st_pin(p_pin[5:2]), .o_st_pin(p_out[5:2]),
		.o_st_pin_oe(p_oe[5:2]), .o_st_pullup(p_pu[5:2]), .i_ua_pin(p_pin[11:6]),
		.o_ua_pin(p_out[11:6]), .o_ua_pin_oe(p_oe[11:6]), .o_ua_pullup(p_pu[11:6]));
	bsp_partner u_far (.i_clock(i_clock), .i_out(p_out), .i_oe(p_oe), .i_pu(p_pu),
		.o_pin(p_pin), .o_alt(p_alt));
	// ---------------
	// Bus and compare
	// ---------------
	task automatic chk(input logic [35:0] g, input logic [35:0] x);
		n_checks++;
		if (g !== x) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic give_verdict();
		if (fails == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= {3'($urandom), lane0};
		@(posedge i_clock);
		penable <= 1'b1;
		// Ready and data are taken as sampled at the completing rising edge
		do begin
			@(posedge i_clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clock);
	endtask : apb
	task automatic wr(input int i, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, ad[i], d, r, e);
		rg[i] = d[7:0] & mk[i%3];
		chk({35'h0, e}, 36'h0);
	endtask : wr
	// Input pins without pull-up float, so their read bits are not compared
	task automatic rd(input int i);
		logic [31:0] r;
		logic e;
		logic [7:0] inb, x, c;
		apb(1'b0, ad[i], 32'h0000_0000, r, e);
		inb = ~rg[6+i%3] & rg[3+i%3] & {8{i < 3}};
		x = (rg[i] & ~inb) | (inb & rg[9+i%3]) | ((i == 3) ? 8'hfc : 8'h00);
		c = ~(inb & ~rg[9+i%3]);
		chk({3'b000, e, r & {24'hff_ffff, c}}, {12'h000, 16'h0000, x & c});
	endtask : rd
	function automatic logic [11:0] lanes(input logic [7:0] c, input logic [7:0] s,
		input logic [7:0] u);
		return {u[5:0], s[6], s[4], s[1:0], c[1:0]};
	endfunction : lanes
	function automatic logic [35:0] pexp(input logic [11:0] a);
		logic [7:0] al[3], o[3], e[3];
		al[0] = {6'h00, a[1:0]};
		al[1] = {1'b0, a[5], 1'b0, a[4], 2'b00, a[3:2]};
		al[2] = {2'b00, a[11:6]};
		for (int p = 0; p < 3; p++) begin
			o[p] = (rg[6+p] & al[p]) | (~rg[6+p] & rg[p]);
			e[p] = rg[6+p] | ~rg[3+p];
		end
		return {lanes(rg[9], rg[10], rg[11]), lanes(e[0], e[1], e[2]), lanes(o[0], o[1], o[2])};
	endfunction : pexp
	task automatic pads();
		logic [11:0] pa;
		for (int j = 0; j < 5; j++) begin
			@(negedge i_clock);
			if (j > 1) chk({p_pu, p_oe, p_out}, pexp(pa));
			pa = p_alt;
		end
		@(posedge i_clock);
	endtask : pads
	// -----
	// Tests
	// -----
	initial begin
		logic [31:0] r;
		logic e;
		void'($urandom(25));
		rg = '{default: 8'h00};
		for (int p = 0; p < 3; p++) rg[3+p] = mk[p];
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		pads();
		for (int i = 0; i < 12; i++) rd(i);
		wr(3, 32'h0000_0000);
		rd(0);
		pads();
		for (int k = 0; k < 60; k++) begin
			wr($urandom_range(11), $urandom);
			pads();
			if (k % 6 == 5) for (int i = 0; i < 12; i++) rd(i);
		end
		for (int i = 6; i < 9; i++) wr(i, 32'hffff_ffff);
		pads();
		// Write without byte lane 0 must leave the latch alone, with no error
		lane0 = 1'b0;
		apb(1'b1, ad[0], 32'hffff_ffff, r, e);
		lane0 = 1'b1;
		chk({35'h0, e}, 36'h0);
		apb(1'b1, 12'h024, 32'hffff_ffff, r, e);
		chk({35'h0, e}, 36'h1);
		for (int i = 0; i < 12; i++) rd(i);
		give_verdict();
	end
	initial begin
		repeat (8000) @(posedge i_clock);
		fails++;
		give_verdict();
	end
endmodule : tb_top
